// >>> rtl/trig_pkg.sv
package trig_pkg;

  // Register offsets (word addresses on the plain register port).
  localparam logic [3:0] OFF_IN_CFG   = 4'h0;
  localparam logic [3:0] OFF_OUT_CFG  = 4'h1;
  localparam logic [3:0] OFF_SETTING  = 4'h2;
  localparam logic [3:0] OFF_STATUS   = 4'h3;
  localparam logic [3:0] OFF_EVENT    = 4'h4;

  // Input config field positions.
  localparam int IN_ACT_LSB    = 0;
  localparam int IN_WIDTH_LSB  = 4;
  localparam int IN_STATUS_BIT = 12;
  localparam int IN_SLOT_LSB   = 16;
  // Output config field positions.
  localparam int OUT_SRC_LSB   = 0;
  localparam int OUT_WIDTH_LSB = 4;
  localparam int OUT_LEVEL_BIT = 12;
  // Setting register: voltage in low half, frequency in high half.
  localparam int SET_FREQ_LSB  = 16;
  // Event register bits (write one to signal).
  localparam int EV_OUT_BIT    = 0;
  localparam int EV_SET_BIT    = 1;
  localparam int EV_PRE_BIT    = 2;
  localparam int EV_SW_TRG_BIT = 3;
  localparam int EV_OUT_TRG_BIT = 4;

  // Frequency limits in units of 0.01 Hz.
  localparam logic [15:0] FREQ_MIN = 16'h1194;
  localparam logic [15:0] FREQ_MAX = 16'hC350;
  localparam logic [3:0]  SLOT_MAX = 4'h9;
  localparam logic [5:0]  WIDTH_MAX = 6'h3C;

  // Time base: one millisecond tick derived from the 200 MHz clock.
  localparam int CLK_MHZ        = 200;
  localparam int TICK_US        = 1000;
  localparam int TICK_CYCLES    = TICK_US * CLK_MHZ;
  localparam int DEF_IN_WIDTH_MS = 5;

  // Reset values.
  localparam logic [31:0] IN_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] OUT_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] SETTING_RST = 32'h1388_0000;

  typedef enum logic [2:0] {
    ACT_NONE    = 3'h0,
    ACT_OUTPUT  = 3'h1,
    ACT_SETTING = 3'h2,
    ACT_PRESET  = 3'h3,
    ACT_TRANS   = 3'h4
  } in_action_t;

  typedef enum logic [2:0] {
    SRC_NONE    = 3'h0,
    SRC_OUTPUT  = 3'h1,
    SRC_SETTING = 3'h2,
    SRC_PRESET  = 3'h3,
    SRC_ALL     = 3'h4
  } out_source_t;

  typedef enum logic [2:0] {
    QS_IDLE  = 3'b001,
    QS_COUNT = 3'b010,
    QS_DONE  = 3'b100
  } qual_state_t;

  // Commands issued to the rest of the instrument.
  typedef struct packed {
    logic        out_load;
    logic        out_val;
    logic        set_load;
    logic [15:0] volt;
    logic [15:0] freq;
    logic        preset_load;
    logic [3:0]  slot;
    logic        trans_start;
  } trig_cmd_t;

endpackage : trig_pkg

// >>> rtl/trigger_pin_controller.sv
`timescale 1ns/1ps

// Contract
// - Five input actions; none ignores pin and remote trigger
// - Output action forces configured on/off state
// - Setting action applies voltage, clamped frequency
// - Preset action loads slot zero to nine
// - Qualify high width; zero means 5 ms
// - Source none ignores internal events
// - Output source fires on on/off change
// - Setting source fires on setting change
// - Preset source fires on load or save
// - All source fires on any event
// - Nonzero width pulses high that many ms
// - Zero width holds level while condition true
// - Action and source ignored during simulate or sequence
module trigger_pin_controller
  import trig_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        trig_in_pin,
  input  wire logic        test_mode_busy,
  input  wire logic        out_state,
  input  wire logic        setting_changed,
  input  wire logic        preset_event,
  input  wire logic        transient_manual,
  output logic             trig_out_pin,
  output trig_cmd_t        cmd
);

  logic [31:0] in_cfg_r;
  logic [31:0] out_cfg_r;
  logic [31:0] setting_r;
  logic [2:0]  pin_sync_r;
  logic        pin_level_r;
  logic [31:0] tick_cnt_r;
  logic        tick_r;
  qual_state_t qs_r;
  logic [5:0]  hi_ms_r;
  logic        fire_r;
  logic        out_state_d_r;
  logic [5:0]  pulse_ms_r;
  logic        cond_r;
  logic        sw_trg_r;
  logic        sw_out_r;
  logic        act_done_r;
  in_action_t  in_act;
  out_source_t out_src;
  logic [5:0]  in_width;
  logic [5:0]  out_width;
  logic        ev_out;
  logic        ev_set;
  logic        ev_pre;
  logic        activate;

  // Clamps a frequency into the permitted window.
  function automatic logic [15:0] clamp_freq(input logic [15:0] f);
    if (f < FREQ_MIN) begin
      return FREQ_MIN;
    end else if (f > FREQ_MAX) begin
      return FREQ_MAX;
    end
    return f;
  endfunction : clamp_freq

  // Limits a width field to the 0..60 ms range.
  function automatic logic [5:0] clamp_width(input logic [5:0] w);
    return (w > WIDTH_MAX) ? WIDTH_MAX : w;
  endfunction : clamp_width

  // Action and source fields are only honoured outside the test modes.
  always_comb begin
    in_act    = in_action_t'(in_cfg_r[IN_ACT_LSB +: 3]);
    out_src   = out_source_t'(out_cfg_r[OUT_SRC_LSB +: 3]);
    in_width  = clamp_width(in_cfg_r[IN_WIDTH_LSB +: 6]);
    out_width = clamp_width(out_cfg_r[OUT_WIDTH_LSB +: 6]);
    if (in_width == 6'h00) begin
      in_width = 6'(DEF_IN_WIDTH_MS);
    end
    if (test_mode_busy) begin
      in_act  = ACT_NONE;
      out_src = SRC_NONE;
    end
  end

  // Register writes; reads return one cycle later.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_cfg_r  <= IN_CFG_RST;
      out_cfg_r <= OUT_CFG_RST;
      setting_r <= SETTING_RST;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        OFF_IN_CFG:  in_cfg_r  <= reg_wdata;
        OFF_OUT_CFG: out_cfg_r <= reg_wdata;
        OFF_SETTING: setting_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Remote trigger commands arrive as one-cycle pulses from the event register.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_trg_r <= 1'b0;
      sw_out_r <= 1'b0;
    end else if (clk_en) begin
      sw_trg_r <= reg_wr && reg_addr == OFF_EVENT && reg_wdata[EV_SW_TRG_BIT];
      sw_out_r <= reg_wr && reg_addr == OFF_EVENT && reg_wdata[EV_OUT_TRG_BIT];
    end
  end

  // Read mux; unmapped addresses read zero.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          OFF_IN_CFG:  reg_rdata <= in_cfg_r;
          OFF_OUT_CFG: reg_rdata <= out_cfg_r;
          OFF_SETTING: reg_rdata <= setting_r;
          OFF_STATUS:  reg_rdata <= {26'h0, hi_ms_r == 6'h00, cond_r,
                                     trig_out_pin, pin_level_r, qs_r == QS_DONE, test_mode_busy};
          default:     reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Three-stage synchroniser; the level changes once stages two and three agree.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_sync_r  <= 3'b000;
      pin_level_r <= 1'b0;
    end else if (clk_en) begin
      pin_sync_r <= {pin_sync_r[1:0], trig_in_pin};
      if (pin_sync_r[1] == pin_sync_r[2]) begin
        pin_level_r <= pin_sync_r[2];
      end
    end
  end

  // Millisecond tick from the system clock; shorten TICK_DIV in simulation.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
    end else if (clk_en) begin
      tick_r <= 1'b0;
      if (tick_cnt_r >= 32'(TICK_DIV - 1)) begin
        tick_cnt_r <= 32'h0000_0000;
        tick_r     <= 1'b1;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      end
    end
  end

  // Width qualifier: one fire per high pulse, counted in whole ticks.
  // A pulse no longer than the width less one tick never fires; a long one fires only once.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      qs_r    <= QS_IDLE;
      hi_ms_r <= 6'h00;
      fire_r  <= 1'b0;
    end else if (clk_en) begin
      fire_r <= 1'b0;
      case (qs_r)
        QS_IDLE: begin
          hi_ms_r <= 6'h00;
          if (pin_level_r) begin
            qs_r <= QS_COUNT;
          end
        end
        QS_COUNT: begin
          if (!pin_level_r) begin
            qs_r <= QS_IDLE;
          end else if (tick_r) begin
            hi_ms_r <= hi_ms_r + 6'h01;
            if (hi_ms_r + 6'h01 >= in_width) begin
              qs_r   <= QS_DONE;
              fire_r <= 1'b1;
            end
          end
        end
        QS_DONE: begin
          if (!pin_level_r) begin
            qs_r <= QS_IDLE;
          end
        end
        default: qs_r <= QS_IDLE;
      endcase
    end
  end

  // Selected action is issued as a one-cycle command.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd        <= '0;
      act_done_r <= 1'b0;
    end else if (clk_en) begin
      cmd.out_load    <= 1'b0;
      cmd.set_load    <= 1'b0;
      cmd.preset_load <= 1'b0;
      cmd.trans_start <= 1'b0;
      act_done_r      <= fire_r;
      if (fire_r || sw_trg_r) begin
        case (in_act)
          ACT_OUTPUT: begin
            cmd.out_load <= 1'b1;
            cmd.out_val  <= in_cfg_r[IN_STATUS_BIT];
          end
          ACT_SETTING: begin
            cmd.set_load <= 1'b1;
            cmd.volt     <= setting_r[15:0];
            cmd.freq     <= clamp_freq(setting_r[SET_FREQ_LSB +: 16]);
          end
          ACT_PRESET: begin
            cmd.preset_load <= 1'b1;
            cmd.slot <= (in_cfg_r[IN_SLOT_LSB +: 4] > SLOT_MAX) ? SLOT_MAX
                        : in_cfg_r[IN_SLOT_LSB +: 4];
          end
          ACT_TRANS: cmd.trans_start <= transient_manual;
          default: ;
        endcase
      end
    end
  end

  // Event sources; state changes are seen on the out_state edge.
  always_comb begin
    ev_out = (out_state != out_state_d_r);
    ev_set = setting_changed;
    ev_pre = preset_event;
    case (out_src)
      SRC_OUTPUT:  activate = ev_out;
      SRC_SETTING: activate = ev_set;
      SRC_PRESET:  activate = ev_pre;
      SRC_ALL:     activate = ev_out | ev_set | ev_pre;
      default:     activate = 1'b0;
    endcase
  end

  // Output pin: pulse for the width, or hold level while the condition stands.
  // Remote output trigger commands pulse regardless of the source.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_state_d_r <= 1'b0;
      pulse_ms_r    <= 6'h00;
      cond_r        <= 1'b0;
      trig_out_pin  <= 1'b0;
    end else if (clk_en) begin
      out_state_d_r <= out_state;
      cond_r        <= activate;
      if (out_width == 6'h00) begin
        pulse_ms_r   <= 6'h00;
        trig_out_pin <= (activate || sw_out_r) ? out_cfg_r[OUT_LEVEL_BIT]
                        : ~out_cfg_r[OUT_LEVEL_BIT];
      end else if (activate || sw_out_r) begin
        pulse_ms_r   <= out_width;
        trig_out_pin <= 1'b1;
      end else if (tick_r && pulse_ms_r != 6'h00) begin
        pulse_ms_r   <= pulse_ms_r - 6'h01;
        trig_out_pin <= (pulse_ms_r != 6'h01);
      end else if (pulse_ms_r == 6'h00) begin
        // Leaving zero-width mode must not strand the pin at the held level.
        trig_out_pin <= 1'b0;
      end
    end
  end

  // Checks.
  chk_once_per_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fire_r |=> !fire_r until !pin_level_r) else $error("Double fire in one pulse.");
  chk_fire_width: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fire_r |-> hi_ms_r >= in_width) else $error("Fire before width.");
  chk_src_none: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (out_src == SRC_NONE) |-> !activate) else $error("Activation with no source.");
  chk_test_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (test_mode_busy && clk_en) |=> !cmd.preset_load && !cmd.set_load)
    else $error("Action during test mode.");
  chk_pulse_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && activate && out_width != 6'h00) |=> trig_out_pin && pulse_ms_r == $past(out_width))
    else $error("Pulse did not start.");
  chk_restart: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && activate && pulse_ms_r != 6'h00 && out_width != 6'h00)
    |=> pulse_ms_r == $past(out_width))
    else $error("Pulse not restarted.");
  chk_freq_clamp: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cmd.set_load |-> cmd.freq >= FREQ_MIN && cmd.freq <= FREQ_MAX)
    else $error("Frequency out of range.");
  chk_slot_range: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cmd.preset_load |-> cmd.slot <= SLOT_MAX) else $error("Slot out of range.");
  chk_out_action: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && fire_r && in_act == ACT_OUTPUT)
    |=> cmd.out_load && cmd.out_val == $past(in_cfg_r[IN_STATUS_BIT]))
    else $error("Output action wrong.");
  chk_hold_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clk_en && out_width == 6'h00 && activate) |=> trig_out_pin == $past(out_cfg_r[OUT_LEVEL_BIT]))
    else $error("Hold level wrong.");

endmodule : trigger_pin_controller

// >>> dv/trig_equipment.sv
`timescale 1ns/1ps

// Behavioural test equipment on the external control connector.
module trig_equipment (
  input  wire logic ref_clk,
  input  wire logic trig_out_pin,
  output logic      trig_in_pin
);
  int   rise_count = 0;
  int   high_len   = 0;
  int   run_len    = 0;
  logic prev_out   = 1'b0;

  initial trig_in_pin = 1'b0;

  // High pulse of a set length; the line idles low between pulses.
  task automatic pulse(input int cycles);
    @(posedge ref_clk);
    trig_in_pin <= 1'b1;
    repeat (cycles) @(posedge ref_clk);
    trig_in_pin <= 1'b0;
  endtask : pulse

  // Counts output rises and keeps the length of the last high stretch.
  always @(posedge ref_clk) begin
    prev_out <= trig_out_pin;
    if (trig_out_pin === 1'b1 && prev_out !== 1'b1) rise_count <= rise_count + 1;
    if (trig_out_pin === 1'b1) run_len <= run_len + 1;
    else begin
      if (run_len != 0) high_len <= run_len;
      run_len <= 0;
    end
  end
endmodule : trig_equipment

// >>> dv/trigger_pin_controller_bench.sv
`timescale 1ns/1ps

module trigger_pin_controller_bench
  import trig_pkg::*;
;
  localparam int TD = 10;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        test_mode_busy = 1'b0, out_state = 1'b0, setting_changed = 1'b0;
  logic        preset_event = 1'b0, transient_manual = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
  logic        trig_in_pin, trig_out_pin;
  trig_cmd_t   cmd;
  int          fail_count = 0, cmp_count = 0, n_out, n_set, n_pre, n_trn;
  int          w, ew, slot, st;
  logic [15:0] v, f;

  always #2.5 ref_clk = ~ref_clk;

  trigger_pin_controller #(.TICK_DIV(TD)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in_pin(trig_in_pin),
    .test_mode_busy(test_mode_busy), .out_state(out_state),
    .setting_changed(setting_changed), .preset_event(preset_event),
    .transient_manual(transient_manual), .trig_out_pin(trig_out_pin), .cmd(cmd));
  trig_equipment i_eqp (.ref_clk(ref_clk), .trig_out_pin(trig_out_pin),
    .trig_in_pin(trig_in_pin));

  // Command pulses are one cycle long, so each high sample is one command.
  always @(posedge ref_clk) begin
    if (cmd.out_load === 1'b1) n_out++;
    if (cmd.set_load === 1'b1) n_set++;
    if (cmd.preset_load === 1'b1) n_pre++;
    if (cmd.trans_start === 1'b1) n_trn++;
  end

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare

  task automatic check_range(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : check_range

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe, so sample it there.
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 compare(reg_rdata, exp);
  endtask : rd_chk

  task automatic fire_event(input int kind);
    @(posedge ref_clk);
    if (kind == 0) out_state <= ~out_state;
    setting_changed <= (kind == 1);
    preset_event <= (kind == 2);
    @(posedge ref_clk);
    setting_changed <= 1'b0;
    preset_event <= 1'b0;
  endtask : fire_event

  function automatic logic [15:0] clamp_freq(input logic [15:0] x);
    return (x < FREQ_MIN) ? FREQ_MIN : ((x > FREQ_MAX) ? FREQ_MAX : x);
  endfunction : clamp_freq

  function automatic logic [31:0] in_cfg(input int a, input int wd, input int s, input int sl);
    return 32'(a) | (32'(wd) << IN_WIDTH_LSB) | (32'(s) << IN_STATUS_BIT) | (32'(sl) << IN_SLOT_LSB);
  endfunction : in_cfg

  // A hang is cut short here and counted as a mismatch.
  initial begin
    #200_000;
    fail_count++;
    end_sim();
  end

  initial begin
    void'($urandom(88));
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk(OFF_IN_CFG, IN_CFG_RST);
    rd_chk(OFF_OUT_CFG, OUT_CFG_RST);
    rd_chk(OFF_SETTING, SETTING_RST);
    rd_chk(4'hF, 32'h0000_0000);
    // Zero-width low level rests the pin high; idle qualifier, zero count.
    rd_chk(OFF_STATUS, 32'h0000_0028);
    // Every input action, with frequency corners below and above the range.
    for (int r = 0; r < 2; r++) begin
      for (int a = 0; a < 5; a++) begin
        w = $urandom_range(0, 4);
        ew = (w == 0) ? DEF_IN_WIDTH_MS : w;
        slot = $urandom_range(0, 15);
        st = $urandom_range(0, 1);
        v = 16'($urandom);
        f = (r == 0) ? 16'h0000 : 16'hFFFF;
        if (a == 2 && $urandom_range(0, 1)) f = 16'($urandom_range(4500, 50000));
        wr(OFF_SETTING, {f, v});
        wr(OFF_IN_CFG, in_cfg(a, w, st, slot));
        {n_out, n_set, n_pre, n_trn} = '0;
        i_eqp.pulse(ew * TD + 40);
        repeat (10) @(posedge ref_clk);
        compare(32'(n_out), 32'(a == 1));
        compare(32'(n_set), 32'(a == 2));
        compare(32'(n_pre), 32'(a == 3));
        compare(32'(n_trn), 32'(a == 4));
        compare(32'(n_out + n_set + n_pre + n_trn), 32'(a != 0));
        if (a == 1) compare(32'(cmd.out_val), 32'(st));
        if (a == 2) compare({cmd.freq, cmd.volt}, {clamp_freq(f), v});
        if (a == 3) compare(32'(cmd.slot), 32'((slot > 9) ? 9 : slot));
      end
    end
    // Pulses one tick short of the width, default width included, are refused.
    for (int k = 0; k < 2; k++) begin
      w = 3 * k;
      ew = (w == 0) ? DEF_IN_WIDTH_MS : w;
      wr(OFF_IN_CFG, in_cfg(ACT_PRESET, w, 0, 1));
      n_pre = 0;
      i_eqp.pulse((ew - 1) * TD - 2);
      repeat (20) @(posedge ref_clk);
      compare(32'(n_pre), 32'h0000_0000);
    end
    // Each source against each internal event kind.
    for (int s = 0; s < 5; s++) begin
      wr(OFF_OUT_CFG, 32'(s) | (32'h1 << OUT_WIDTH_LSB));
      for (int k = 0; k < 3; k++) begin
        i_eqp.rise_count = 0;
        fire_event(k);
        repeat (25) @(posedge ref_clk);
        compare(32'(i_eqp.rise_count), 32'(s == 4 || s == k + 1));
      end
    end
    i_eqp.rise_count = 0;
    wr(OFF_EVENT, 32'h1 << EV_OUT_TRG_BIT);
    repeat (25) @(posedge ref_clk);
    compare(32'(i_eqp.rise_count), 32'h0000_0001);
    // Simulate or sequence running blocks both pins.
    test_mode_busy <= 1'b1;
    wr(OFF_OUT_CFG, 32'(SRC_ALL) | (32'h2 << OUT_WIDTH_LSB));
    wr(OFF_IN_CFG, in_cfg(ACT_PRESET, 1, 0, 2));
    {n_pre, i_eqp.rise_count} = '0;
    fire_event(1);
    i_eqp.pulse(3 * TD);
    repeat (10) @(posedge ref_clk);
    compare(32'(n_pre + i_eqp.rise_count), 32'h0000_0000);
    test_mode_busy <= 1'b0;
    // Transient action is refused unless the transient mode is manual.
    transient_manual <= 1'b0;
    wr(OFF_IN_CFG, in_cfg(ACT_TRANS, 1, 0, 0));
    n_trn = 0;
    i_eqp.pulse(3 * TD);
    repeat (10) @(posedge ref_clk);
    compare(32'(n_trn), 32'h0000_0000);
    transient_manual <= 1'b1;
    // Pulse widths at both ends and one random, with a random polarity bit.
    for (int k = 0; k < 3; k++) begin
      w = (k == 0) ? 1 : ((k == 1) ? 60 : $urandom_range(2, 10));
      wr(OFF_OUT_CFG, 32'(SRC_SETTING) | (32'(w) << OUT_WIDTH_LSB) |
         (32'($urandom_range(0, 1)) << OUT_LEVEL_BIT));
      fire_event(1);
      repeat (w * TD + 20) @(posedge ref_clk);
      check_range(i_eqp.high_len, (w - 1) * TD, w * TD + 2);
    end
    fire_event(1);
    repeat (15) @(posedge ref_clk);
    fire_event(1);
    repeat (w * TD + 25) @(posedge ref_clk);
    check_range(i_eqp.high_len, 15 + (w - 1) * TD, 20 + w * TD);
    // Zero width: the pin rests at the inverse level and shows the level per event.
    for (int l = 0; l < 2; l++) begin
      wr(OFF_OUT_CFG, 32'(SRC_SETTING) | (32'(l) << OUT_LEVEL_BIT));
      repeat (3) @(posedge ref_clk);
      compare(32'(trig_out_pin), 32'(l == 0));
      i_eqp.rise_count = 0;
      fire_event(1);
      repeat (5) @(posedge ref_clk);
      compare({31'h0, trig_out_pin}, 32'(l == 0));
      compare(32'(i_eqp.rise_count), 32'h0000_0001);
    end
    end_sim();
  end
endmodule : trigger_pin_controller_bench
